// >>> rtl/camio_consts.svh
/*
 * Register offsets, field positions, reset values and encodings for the
 * camera I/O line control block.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
`ifndef CAMIO_CONSTS_SVH
`define CAMIO_CONSTS_SVH

`define OFS_MODE        8'h00
`define OFS_TRIG_SRC    8'h04
`define OFS_LINE_SEL    8'h08
`define OFS_LINE_INV    8'h0c
`define OFS_LINE_STAT   8'h10
`define OFS_STAT_ALL    8'h14
`define OFS_OUT_SRC     8'h18

`define SEL_OUT_BASE    3'h2
`define MODE_RST        1'h0
`define INV_RST         1'h0
`define LINE_SEL_RST    3'h0
`define OUT_SRC_RST     8'h04
`define TRIG_LEGACY_RST 2'h1
`define TRIG_STD_RST    2'h1

`endif

// >>> rtl/camio_lines.sv
/*
 * Camera opto-isolated line control: two inputs, four outputs, trigger
 * routing, inversion, readback, output source mapping, Wishbone slave.
 * Assumes input pins are asynchronous to REF_CLK and that exposure and
 * trigger-accept status come from logic on REF_CLK.
 */
// The register offsets and register access over Wishbone were decided locally.
`include "camio_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Two input lines, each seen internally as one logic level.
// - Four output lines, each driven from one internal logic level.
// - Output one means the output switch conducts, zero means it is off.
// - Standard mode reset: input 1 is the frame start trigger.
// - Standard mode reset: input 2 is the acquisition start trigger.
// - Legacy mode reset: input 1 is the single acquisition start trigger.
// - Apart from the standard mode default, at most one input line is the external trigger source at a time.
// - The line assigned as trigger source is not offered as a user input.
// - Any unassigned input line serves as a user input.
// - Software reads one selected line level and all levels together.
// - Each input line has its own independent inversion control.
// - Inversion is set by selecting a line, then writing the inverter bit.
// - After reset output 1 carries the exposure-in-progress signal.
// - After reset output 2 carries the trigger-accept signal.
// - Trigger-accept rises when the next exposure start may be triggered.
// - Software can change which internal signal drives each output.
module camio_lines
  import camio_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic        CLK_EN,
  input  wire logic [1:0]  LINE_IN,
  input  wire logic        EXPOSURE_IN_PROGRESS,
  input  wire logic        TRIGGER_ACCEPT_WINDOW,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic      [3:0]  LINE_OUT,
  output logic             FRAME_START_TRIGGER,
  output logic             ACQ_START_TRIGGER,
  output logic      [1:0]  USER_INPUT,
  output logic      [1:0]  USER_INPUT_VALID
);

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic       legacy_mode;
  logic [1:0] trig_src;
  logic       trig_written;
  logic [2:0] line_sel;
  logic [7:0] out_src;

  // A request is taken only while no acknowledge is pending, so a master
  // that holds its strobe through the acknowledge is served exactly once.
  wire bus_req  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire bus_take = CLK_EN & bus_req;
  wire bus_wr   = bus_take & WB_WE_I & WB_SEL_I[0];

  wire hit_mode = WB_ADR_I == `OFS_MODE;
  wire hit_trig = WB_ADR_I == `OFS_TRIG_SRC;
  wire hit_sel  = WB_ADR_I == `OFS_LINE_SEL;
  wire hit_inv  = WB_ADR_I == `OFS_LINE_INV;
  wire hit_stat = WB_ADR_I == `OFS_LINE_STAT;
  wire hit_all  = WB_ADR_I == `OFS_STAT_ALL;
  wire hit_osrc = WB_ADR_I == `OFS_OUT_SRC;

  // The selector spans inputs 0..1 and outputs 2..5.
  wire sel_is_in = line_sel < `SEL_OUT_BASE;
  wire sel_idx   = line_sel[0];

  wire wr_mode = bus_wr & hit_mode;
  wire wr_trig = bus_wr & hit_trig;
  wire wr_sel  = bus_wr & hit_sel;
  wire wr_osrc = bus_wr & hit_osrc;
  // Output lines have no inverter here, so such a write is dropped.
  wire wr_inv  = bus_wr & hit_inv & sel_is_in;

  //////////////////////////////////////////////////////////////////////////////
  // Input lines: a synchroniser and an inverter for each line.

  wire [1:0] inv;
  wire [1:0] level;

  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : g_line
      logic stage_a;
      logic stage_b;
      logic inverted;
      // Each line keeps its own inverter bit and takes a write only while
      // it is the selected line, so the two settings never disturb each
      // other.
      wire  wr_this = wr_inv & (sel_idx == 1'(s));

      // Only the second stage is read, so a metastable first stage never
      // reaches routing or readback.
      always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
          stage_a <= 1'b0;
          stage_b <= 1'b0;
        end else if (CLK_EN) begin
          stage_a <= LINE_IN[s];
          stage_b <= stage_a;
        end
      end

      always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
          inverted <= `INV_RST;
        end else if (wr_this) begin
          inverted <= WB_DAT_I[0];
        end
      end

      // Both trigger routing and readback read the inverted level.
      assign inv[s]   = inverted;
      assign level[s] = stage_b ^ inverted;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      legacy_mode <= `MODE_RST;
    end else if (wr_mode) begin
      legacy_mode <= WB_DAT_I[0];
    end
  end

  // Only one encoding per line can be held, so two sources cannot coexist.
  wire [1:0] next_trig_src = (WB_DAT_I[1:0] == 2'h3) ? 2'h0
                                                     : WB_DAT_I[1:0];

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      trig_src     <= `TRIG_STD_RST;
      trig_written <= 1'b0;
    end else if (wr_trig) begin
      trig_src     <= next_trig_src;
      trig_written <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      line_sel <= `LINE_SEL_RST;
    end else if (wr_sel) begin
      line_sel <= WB_DAT_I[2:0];
    end
  end

  // The reset map puts exposure on output 1 and trigger accept on output 2.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      out_src <= `OUT_SRC_RST;
    end else if (wr_osrc) begin
      out_src <= WB_DAT_I[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Trigger routing and user inputs.

  // Until software picks a source, the mode decides the default routing.
  wire [1:0] eff_trig = trig_written ? trig_src
                                     : (legacy_mode ? `TRIG_LEGACY_RST
                                                    : `TRIG_STD_RST);

  wire std_default = ~trig_written & ~legacy_mode;
  wire pick_line1  = eff_trig == TRIG_LINE1;
  wire pick_line2  = eff_trig == TRIG_LINE2;

  // A single chosen line feeds frame start in standard mode and
  // acquisition start in legacy mode; the other start stays low.
  wire routed = (pick_line1 & level[0]) | (pick_line2 & level[1]);

  // The standard default is the one case that uses both lines at once.
  wire next_frame = std_default ? level[0]
                                : ~legacy_mode & routed;
  wire next_acq   = std_default ? level[1]
                                : legacy_mode & routed;

  wire [1:0] assigned;
  assign assigned[0] = std_default | pick_line1;
  assign assigned[1] = std_default | pick_line2;

  wire [1:0] next_user  = level & ~assigned;
  wire [1:0] next_valid = ~assigned;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      FRAME_START_TRIGGER <= 1'b0;
    end else if (CLK_EN) begin
      FRAME_START_TRIGGER <= next_frame;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ACQ_START_TRIGGER <= 1'b0;
    end else if (CLK_EN) begin
      ACQ_START_TRIGGER <= next_acq;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      USER_INPUT <= 2'h0;
    end else if (CLK_EN) begin
      USER_INPUT <= next_user;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      USER_INPUT_VALID <= 2'h0;
    end else if (CLK_EN) begin
      USER_INPUT_VALID <= next_valid;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output mapping: two bits of source per line.

  wire [3:0] next_out;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_out
      wire [1:0] src      = out_src[2*g+1:2*g];
      wire       take_exp = src == SRC_EXPOSURE;
      wire       take_acc = src == SRC_TRIG_OK;
      wire       take_one = src == SRC_HIGH;

      // A low selection is the only case left, so it needs no term.
      assign next_out[g] = (take_exp & EXPOSURE_IN_PROGRESS)
                         | (take_acc & TRIGGER_ACCEPT_WINDOW)
                         | take_one;
    end
  endgenerate

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      LINE_OUT <= 4'h0;
    end else if (CLK_EN) begin
      LINE_OUT <= next_out;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone read data and acknowledge.

  // The answer comes one cycle after the request is taken. Read data is
  // zero outside the acknowledge, so a late sample never shows stale state.
  wire [1:0]  out_pick = line_sel[1:0] - 2'h2;
  wire        stat_in  = level[sel_idx];
  wire        stat_out = LINE_OUT[out_pick];
  wire        stat_bit = sel_is_in ? stat_in : stat_out;
  wire        inv_bit  = sel_is_in & inv[sel_idx];

  wire [31:0] rd_mode = {31'h0, legacy_mode};
  wire [31:0] rd_trig = {30'h0, eff_trig};
  wire [31:0] rd_sel  = {29'h0, line_sel};
  wire [31:0] rd_inv  = {31'h0, inv_bit};
  wire [31:0] rd_stat = {31'h0, stat_bit};
  wire [31:0] rd_all  = {26'h0, LINE_OUT, level};
  wire [31:0] rd_osrc = {24'h0, out_src};

  wire [31:0] next_dat = hit_mode ? rd_mode
                       : hit_trig ? rd_trig
                       : hit_sel  ? rd_sel
                       : hit_inv  ? rd_inv
                       : hit_stat ? rd_stat
                       : hit_all  ? rd_all
                       : hit_osrc ? rd_osrc
                       : 32'h0;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      WB_ACK_O <= 1'b0;
    end else if (CLK_EN) begin
      WB_ACK_O <= bus_req;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      WB_DAT_O <= 32'h0;
    end else if (CLK_EN) begin
      WB_DAT_O <= bus_req ? next_dat : 32'h0;
    end
  end

endmodule : camio_lines

// >>> rtl/camio_pkg.sv
/*
 * Types shared by the camera I/O line control block.
 * Assumes the constants header is included by the design file.
 */
package camio_pkg;
  typedef enum logic [1:0] {
    SRC_EXPOSURE = 2'b00,
    SRC_TRIG_OK  = 2'b01,
    SRC_LOW      = 2'b10,
    SRC_HIGH     = 2'b11
  } out_src_type;

  typedef enum logic [1:0] {
    TRIG_NONE  = 2'b00,
    TRIG_LINE1 = 2'b01,
    TRIG_LINE2 = 2'b10
  } trig_src_type;
endpackage : camio_pkg

// >>> verif/cam_far_side.sv
/* Far-side model: the trigger sources on the two opto inputs.
   Assumes the bench commands the wanted line levels. */
module cam_far_side (
  input  wire logic       REF_CLK,
  input  wire logic [1:0] want,
  output logic      [1:0] LINE_IN
);
  timeunit 1ns;
  timeprecision 1ps;
  // Opto lines carry plain levels, so the source just follows its command.
  always @(posedge REF_CLK) LINE_IN <= want;
endmodule : cam_far_side

// >>> verif/camio_lines_assertions.sv
/* Port checker for camio_lines, bound to every instance.
   Assumes CLK_EN is held high while the bench runs. */
module camio_lines_chk (
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  input wire logic        CLK_EN,
  input wire logic [1:0]  LINE_IN,
  input wire logic        EXPOSURE_IN_PROGRESS,
  input wire logic        TRIGGER_ACCEPT_WINDOW,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic [3:0]  LINE_OUT,
  input wire logic        FRAME_START_TRIGGER,
  input wire logic        ACQ_START_TRIGGER,
  input wire logic [1:0]  USER_INPUT,
  input wire logic [1:0]  USER_INPUT_VALID
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  sequence quiet_s;
    !WB_CYC_I && $stable(LINE_IN);
  endsequence
  ack_once_a: assert property (WB_ACK_O && CLK_EN |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  ack_resp_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN
    |=> WB_ACK_O) else $error("request not answered");
  ack_cause_a: assert property ($rose(WB_ACK_O)
    |-> $past(WB_CYC_I && WB_STB_I)) else $error("ack without request");
  dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
  user_gate_a: assert property ((USER_INPUT & ~USER_INPUT_VALID) == 2'h0)
    else $error("trigger line shown as user input");
  reset_map_a: assert property ($rose(RST_B) |=> LINE_OUT[1:0] ==
    {$past(TRIGGER_ACCEPT_WINDOW), $past(EXPOSURE_IN_PROGRESS)})
    else $error("output map wrong after reset");
  reset_route_a: assert property ($rose(RST_B) |=>
    USER_INPUT_VALID == 2'b00) else $error("user lines wrong after reset");
  quiet_hold_a: assert property (quiet_s [*4] |=>
    $stable({FRAME_START_TRIGGER, ACQ_START_TRIGGER, USER_INPUT}))
    else $error("input outputs moved without cause");
endmodule : camio_lines_chk

bind camio_lines camio_lines_chk i_camio_lines_chk (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .CLK_EN(CLK_EN), .LINE_IN(LINE_IN),
  .EXPOSURE_IN_PROGRESS(EXPOSURE_IN_PROGRESS),
  .TRIGGER_ACCEPT_WINDOW(TRIGGER_ACCEPT_WINDOW), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .LINE_OUT(LINE_OUT), .FRAME_START_TRIGGER(FRAME_START_TRIGGER),
  .ACQ_START_TRIGGER(ACQ_START_TRIGGER), .USER_INPUT(USER_INPUT),
  .USER_INPUT_VALID(USER_INPUT_VALID));

// >>> verif/tb_camio_lines.sv
/* Self-checking bench for camio_lines.
   Assumes the constants header and the far-side model are compiled. */
`include "camio_consts.svh"
module tb_camio_lines;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, expo = 1, tacc = 0;
  logic [7:0]  adr = 8'h0;
  logic [31:0] wdat = 32'h0, dat_o, rd;
  logic [1:0]  want = 2'h0, line_in, ui, uiv;
  logic [3:0]  line_out;
  logic        ack, fst, ast;
  int n_errors = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  cam_far_side i_cam_far_side (.REF_CLK(clk), .want(want), .LINE_IN(line_in));
  camio_lines i_camio_lines (.REF_CLK(clk), .RST_B(rst_b), .CLK_EN(1'b1),
    .LINE_IN(line_in), .EXPOSURE_IN_PROGRESS(expo),
    .TRIGGER_ACCEPT_WINDOW(tacc), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .LINE_OUT(line_out),
    .FRAME_START_TRIGGER(fst), .ACQ_START_TRIGGER(ast), .USER_INPUT(ui),
    .USER_INPUT_VALID(uiv));
  task chk(string name, logic [31:0] seen, logic [31:0] expct);
    n_compared++;
    if (seen !== expct) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, expct, seen);
    end
  endtask : chk
  // Only the watchdog ends a wait for the acknowledge.
  task wb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    {cyc, stb, we} <= 3'b000;
  endtask : wb
  // Three edges of input latency plus one in the far-side model.
  task settle;
    repeat (5) @(posedge clk);
  endtask : settle
  task t_reset;
    repeat (2) @(posedge clk);
    chk("out", line_out[1:0], 2'b01);
    chk("valid", uiv, 2'b00);
    {expo, tacc} <= 2'b01;
    repeat (2) @(posedge clk);
    chk("out", line_out[1:0], 2'b10);
  endtask : t_reset
  task t_std;
    want <= 2'b01;
    settle;
    chk("frame", {fst, ast}, 2'b10);
    want <= 2'b10;
    settle;
    chk("acq", {fst, ast}, 2'b01);
  endtask : t_std
  task t_legacy;
    wb(1, `OFS_MODE, 1);
    want <= 2'b01;
    settle;
    chk("legacy", {fst, ast}, 2'b01);
    chk("valid", uiv, 2'b10);
    wb(1, `OFS_MODE, 0);
  endtask : t_legacy
  task t_route;
    wb(1, `OFS_TRIG_SRC, 2);
    want <= 2'b11;
    settle;
    chk("valid", uiv, 2'b01);
    chk("user", ui, 2'b01);
    chk("frame", fst, 1);
    wb(0, `OFS_STAT_ALL, 0);
    chk("all", rd[1:0], 2'b11);
    wb(1, `OFS_LINE_SEL, 0);
    wb(0, `OFS_LINE_STAT, 0);
    chk("one", rd, 1);
    wb(0, `OFS_TRIG_SRC, 0);
    chk("src", rd, 2);
    wb(1, `OFS_TRIG_SRC, 3);
    settle;
    chk("none", uiv, 2'b11);
    chk("user", ui, 2'b11);
    chk("start", {fst, ast}, 2'b00);
    wb(1, `OFS_TRIG_SRC, 2);
  endtask : t_route
  task t_inv;
    wb(1, `OFS_LINE_SEL, 1);
    wb(1, `OFS_LINE_INV, 1);
    settle;
    chk("frame", fst, 0);
    chk("user", ui, 2'b01);
    wb(0, `OFS_STAT_ALL, 0);
    chk("all", rd[1:0], 2'b01);
    wb(1, `OFS_LINE_INV, 0);
    settle;
    chk("frame", fst, 1);
  endtask : t_inv
  task t_out;
    wb(1, `OFS_OUT_SRC, 32'h1e);
    {expo, tacc} <= 2'b10;
    repeat (2) @(posedge clk);
    chk("out", line_out, 4'b1010);
    wb(0, 8'h1c, 0);
    chk("gap", rd, 0);
  endtask : t_out
  task finish_test;
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1;
    t_reset;
    t_std;
    t_legacy;
    t_route;
    t_inv;
    t_out;
    finish_test;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    finish_test;
  end
endmodule : tb_camio_lines
